//--- pkg/epv_pkg.sv
// Constants for exception priority and vector logic
`default_nettype none
package epv_pkg;
  localparam int          EPV_NUM_EXC     = 60;
  localparam int          EPV_NUM_IRQ     = 44;
  localparam int          EPV_VEC_W       = 6;
  localparam int          EPV_PRI_W       = 3;
  localparam int          EPV_IRQ_BASE    = 16;
  localparam logic [31:0] EPV_IRQ_OFFSET  = 32'h0000_0040;
  localparam logic [31:0] EPV_RESET_BASE  = 32'h0000_0000;
  localparam logic [31:0] EPV_BASE_MIN    = 32'h0000_0100;
  localparam logic [31:0] EPV_BASE_MAX    = 32'h3fff_ff00;
  localparam int          EPV_ALIGN_LSB   = 8;
  localparam logic [2:0]  EPV_PRI_RESET   = 3'h0;
  localparam logic [5:0]  EPV_VEC_NMI     = 6'h02;
  localparam logic [5:0]  EPV_VEC_HARD    = 6'h03;
  localparam logic [4:0]  EPV_LVL_NMI     = 5'h00;
  localparam logic [4:0]  EPV_LVL_HARD    = 5'h01;
  localparam logic [4:0]  EPV_LVL_PROG0   = 5'h02;
  localparam logic [4:0]  EPV_LVL_IDLE    = 5'h1f;
  // Implemented exceptions: 2..6, 11, 12, 14, 15 and non-reserved irqs
  localparam logic [59:0] EPV_IMPL_MASK   = 60'h807_f3ff_cdff_d87c;
endpackage : epv_pkg
`default_nettype wire

//--- rtl/epv_arbiter.sv
// Combinational winner search over all eligible requests (pending and enabled, or nmi and hard fault)
`timescale 1ns/1ps
`default_nettype none
module epv_arbiter
  import epv_pkg::*;
#(
  parameter int N = EPV_NUM_EXC
) (
  input  wire logic [N-1:0]   req_i,
  input  wire logic [N*5-1:0] lvl_i,
  output logic                any_o,
  output logic [5:0]          vec_o,
  output logic [4:0]          lvl_o
);
  // Strict less-than keeps the smallest number on ties
  always_comb begin
    any_o = 1'b0;
    vec_o = 6'h00;
    lvl_o = EPV_LVL_IDLE;
    for (int i = 0; i < N; i++) begin
      if (req_i[i] && (!any_o || lvl_i[i*5 +: 5] < lvl_o)) begin
        any_o = 1'b1;
        vec_o = 6'(i);
        lvl_o = lvl_i[i*5 +: 5];
      end
    end
  end
endmodule : epv_arbiter
`default_nettype wire

//--- rtl/epv_core.sv
// Exception prioritisation, preemption and vector address generation
`timescale 1ns/1ps
`default_nettype none
module epv_core
  import epv_pkg::*;
(
  input  wire logic                    ref_clk_i,
  input  wire logic                    rstn_i,
  input  wire logic [EPV_NUM_IRQ-1:0]  irq_line_i,
  input  wire logic                    nmi_i,
  input  wire logic                    hard_fault_i,
  input  wire logic [EPV_NUM_EXC-1:0]  sw_pend_i,
  input  wire logic [EPV_NUM_EXC-1:0]  enable_i,
  input  wire logic                    pri_we_i,
  input  wire logic [5:0]              pri_sel_i,
  input  wire logic [2:0]              pri_val_i,
  input  wire logic                    priv_i,
  input  wire logic                    base_we_i,
  input  wire logic [31:0]             base_val_i,
  input  wire logic                    take_i,
  input  wire logic                    done_i,
  output logic                         req_o,
  output logic [5:0]                   vec_o,
  output logic [31:0]                  fetch_addr_o,
  output logic                         sp_fetch_o,
  output logic [4:0]                   active_lvl_o,
  output logic [31:0]                  base_o,
  output logic [EPV_NUM_EXC-1:0]       pending_o
);
  // Levels: 0 nmi, 1 hard fault, 2..9 programmable 0..7, 31 idle
  typedef struct packed {
    logic [EPV_NUM_IRQ-1:0]  irq_s1;
    logic [EPV_NUM_IRQ-1:0]  irq_s2;
    logic                    nmi_s1;
    logic                    nmi_s2;
    logic [EPV_NUM_EXC-1:0]  pend;
    logic [EPV_NUM_EXC*3-1:0] pri;
    logic [31:0]             base;
    logic [5:0]              act_vec;
    logic [4:0]              act_lvl;
    logic                    active;
    logic [4:0]              stk_lvl;
    logic                    req;
    logic [5:0]              vec;
    logic [31:0]             addr;
    logic                    sp_fetch;
  } epv_state_t;

  epv_state_t             st;
  epv_state_t             next_st;
  logic [EPV_NUM_EXC-1:0] cand;
  logic [EPV_NUM_EXC*5-1:0] lvl;
  logic                   win_any;
  logic [5:0]             win_vec;
  logic [4:0]             win_lvl;
  logic [EPV_NUM_EXC-1:0] raw_set;
  logic                   preempt;

  // Per-exception level and eligibility
  genvar g;
  generate
    for (g = 0; g < EPV_NUM_EXC; g++) begin : g_lvl
      if (g == EPV_VEC_NMI) begin : g_nmi
        assign lvl[g*5 +: 5] = EPV_LVL_NMI;
      end else if (g == EPV_VEC_HARD) begin : g_hf
        assign lvl[g*5 +: 5] = EPV_LVL_HARD;
      end else begin : g_prog
        assign lvl[g*5 +: 5] = EPV_LVL_PROG0 + {2'h0, st.pri[g*3 +: 3]};
      end
      // Nmi and hard fault bypass enables
      if (g == EPV_VEC_NMI || g == EPV_VEC_HARD) begin : g_fix
        assign cand[g] = st.pend[g];
      end else begin : g_en
        assign cand[g] = st.pend[g] && enable_i[g];
      end
    end
  endgenerate

  epv_arbiter #(
    .N (EPV_NUM_EXC)
  ) i_epv_arbiter (
    .req_i (cand),
    .lvl_i (lvl),
    .any_o (win_any),
    .vec_o (win_vec),
    .lvl_o (win_lvl)
  );

  always_comb begin
    raw_set = sw_pend_i;
    raw_set[EPV_IRQ_BASE +: EPV_NUM_IRQ] =
      sw_pend_i[EPV_IRQ_BASE +: EPV_NUM_IRQ] | st.irq_s2;
    raw_set[EPV_VEC_NMI] = sw_pend_i[EPV_VEC_NMI] | st.nmi_s2;
    raw_set[EPV_VEC_HARD] = sw_pend_i[EPV_VEC_HARD] | hard_fault_i;
    raw_set = raw_set & EPV_IMPL_MASK;
  end

  // Only a strictly lower level value may preempt
  assign preempt = win_any && (!st.active || win_lvl < st.act_lvl);

  always_comb begin
    next_st        = st;
    next_st.irq_s1 = irq_line_i;
    next_st.irq_s2 = st.irq_s1;
    next_st.nmi_s1 = nmi_i;
    next_st.nmi_s2 = st.nmi_s1;
    next_st.sp_fetch = 1'b0;
    // Taking clears the winner; a new set in the same cycle wins
    if (take_i && st.req) begin
      next_st.pend[st.vec] = 1'b0;
      next_st.stk_lvl  = st.active ? st.act_lvl : EPV_LVL_IDLE;
      next_st.act_vec  = st.vec;
      next_st.act_lvl  = lvl[st.vec*5 +: 5];
      next_st.active   = 1'b1;
    end else if (done_i && st.active) begin
      // One level of return history only; deeper nests resume at idle
      next_st.act_lvl = st.stk_lvl;
      next_st.active  = (st.stk_lvl != EPV_LVL_IDLE);
      next_st.stk_lvl = EPV_LVL_IDLE;
    end
    next_st.pend = next_st.pend | raw_set;
    if (pri_we_i && pri_sel_i < 6'(EPV_NUM_EXC)) begin
      next_st.pri[pri_sel_i*3 +: 3] = pri_val_i;
    end
    if (base_we_i && priv_i && base_val_i >= EPV_BASE_MIN
        && base_val_i <= EPV_BASE_MAX) begin
      // Low bits dropped, so a misaligned write still lands aligned
      next_st.base = {base_val_i[31:EPV_ALIGN_LSB], 8'h00};
    end
    next_st.req = preempt && !(take_i && st.req);
    next_st.vec = win_vec;
    // New base used at once so a write never pairs an old base with a vector
    next_st.addr = next_st.base + {24'h0, win_vec, 2'b00};
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st          <= '0;
      st.pri      <= {EPV_NUM_EXC{EPV_PRI_RESET}};
      st.base     <= EPV_RESET_BASE;
      st.act_lvl  <= EPV_LVL_IDLE;
      st.stk_lvl  <= EPV_LVL_IDLE;
      st.sp_fetch <= 1'b1;
      st.addr     <= EPV_RESET_BASE;
    end else begin
      st <= next_st;
    end
  end

  assign req_o        = st.req;
  assign vec_o        = st.vec;
  assign fetch_addr_o = st.addr;
  assign sp_fetch_o   = st.sp_fetch;
  assign active_lvl_o = st.act_lvl;
  assign base_o       = st.base;
  assign pending_o    = st.pend;

  // One clock and one reset for every check below
  default clocking cb_epv @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Entry: a taken winner turns active and its request drops
  sequence s_taken;
    st.req && take_i;
  endsequence

  sequence s_entered;
    st.active && !st.req;
  endsequence

  // Return from the outermost handler leaves nothing active
  sequence s_last_return;
    done_i && st.active && !(take_i && st.req)
      && st.stk_lvl == EPV_LVL_IDLE;
  endsequence

  sequence s_back_idle;
    !st.active && st.act_lvl == EPV_LVL_IDLE;
  endsequence

  a_reserved_never: assert property (
    (st.pend & ~EPV_IMPL_MASK) == '0)
    else $error("reserved exception pending");

  a_vec_impl: assert property (
    st.req |-> EPV_IMPL_MASK[st.vec])
    else $error("reserved vector requested");

  a_addr_formed: assert property (
    st.req |-> st.addr == st.base + {24'h0, st.vec, 2'b00})
    else $error("fetch address mismatch");

  // Stack pointer entry is only fetched straight after reset
  a_sp_first: assert property (
    st.sp_fetch |-> st.addr == EPV_RESET_BASE && !st.req)
    else $error("stack entry fetch wrong");

  a_no_equal_pre: assert property (
    (st.active && win_lvl >= st.act_lvl && !done_i) |=> !st.req)
    else $error("equal priority preempted");

  a_higher_pre: assert property (
    (win_any && !st.active && !(take_i && st.req)) |=> st.req)
    else $error("idle request not raised");

  a_nest_pre: assert property (
    (win_any && st.active && win_lvl < st.act_lvl
      && !(take_i && st.req)) |=> st.req)
    else $error("urgent request not raised");

  a_entry_taken: assert property (
    s_taken |=> s_entered)
    else $error("taken winner not entered");

  a_return_idle: assert property (
    s_last_return |=> s_back_idle)
    else $error("last return not idle");

  a_pend_kept: assert property (
    (st.pend[EPV_IRQ_BASE] && !(take_i && st.req && st.vec == 6'h10))
    |=> st.pend[EPV_IRQ_BASE])
    else $error("pending irq dropped");

  a_nmi_wins: assert property (
    cand[EPV_VEC_NMI] |-> win_vec == EPV_VEC_NMI)
    else $error("nmi lost arbitration");

  // Nothing programmable can reach below the nmi level
  a_nmi_kept: assert property (
    (st.active && st.act_lvl == EPV_LVL_NMI) |-> !preempt)
    else $error("nmi handler preempted");

  // Pin passes two sync stages before it pends
  a_nmi_set: assert property (
    nmi_i |-> ##3 st.pend[EPV_VEC_NMI])
    else $error("nmi not latched");

  a_hard_over: assert property (
    (cand[EPV_VEC_HARD] && !cand[EPV_VEC_NMI]) |-> win_vec == EPV_VEC_HARD)
    else $error("hard fault lost");

  a_hf_set: assert property (
    hard_fault_i |=> st.pend[EPV_VEC_HARD])
    else $error("hard fault not latched");

  a_base_range: assert property (
    $changed(st.base) |-> st.base >= EPV_BASE_MIN && st.base <= EPV_BASE_MAX
    && st.base[7:0] == 8'h00)
    else $error("base out of range");

  a_base_priv: assert property (
    (base_we_i && !priv_i) |=> $stable(st.base))
    else $error("unprivileged base write");

  a_base_hold: assert property (
    !base_we_i |=> $stable(st.base))
    else $error("base moved unasked");

  // Irq pin passes two sync stages before it pends
  a_irq_sync: assert property (
    (irq_line_i[0] && enable_i[EPV_IRQ_BASE]) |-> ##3 st.pend[EPV_IRQ_BASE])
    else $error("irq line not latched");

  a_sw_set: assert property (
    sw_pend_i[EPV_IRQ_BASE] |=> st.pend[EPV_IRQ_BASE])
    else $error("software pend lost");

  a_prog_range: assert property (
    (win_any && win_vec != EPV_VEC_NMI && win_vec != EPV_VEC_HARD)
    |-> win_lvl >= EPV_LVL_PROG0 && win_lvl <= EPV_LVL_PROG0 + 5'h07)
    else $error("programmable level out of range");

  // Equal levels on two lines must leave the lower number winning
  a_tie_low: assert property (
    (cand[EPV_IRQ_BASE+1] && cand[EPV_IRQ_BASE+3]
      && lvl[(EPV_IRQ_BASE+1)*5 +: 5] == lvl[(EPV_IRQ_BASE+3)*5 +: 5])
    |-> win_vec != 6'h13)
    else $error("tie not resolved low");

  a_pri_write: assert property (
    (pri_we_i && pri_sel_i == 6'h10)
    |=> st.pri[EPV_IRQ_BASE*3 +: 3] == $past(pri_val_i))
    else $error("priority write lost");
endmodule : epv_core
`default_nettype wire

//--- sim/epv_core_model.sv
// Processor core stand-in: takes winners, returns after a hold time
`timescale 1ns/1ps
`default_nettype none
module epv_core_model (
  input  wire logic       clk_i,
  input  wire logic       req_i,
  input  wire logic       go_i,
  input  wire logic [7:0] hold_i,
  output logic            take_o,
  output logic            done_o
);
  int t[$];
  initial {take_o, done_o} = 2'h0;
  // Only the innermost handler runs, so only its timer counts
  always @(negedge clk_i) begin
    take_o <= 1'b0;
    done_o <= 1'b0;
    if (t.size() > 0) t[$]--;
    // Return never shares a cycle with a take
    if (t.size() > 0 && t[$] <= 0) begin
      done_o <= 1'b1;
      void'(t.pop_back());
    end else if (req_i && go_i && !take_o) begin
      take_o <= 1'b1;
      t.push_back(hold_i);
    end
  end
endmodule : epv_core_model
`default_nettype wire

//--- sim/exception_priority_vector_logic_tb_top.sv
// Self-checking bench for exception priority and vector logic
`timescale 1ns/1ps
`default_nettype none
module exception_priority_vector_logic_tb_top
  import epv_pkg::*;
;
  logic        clk = 1'b0, rstn = 1'b0, nmi = 1'b0, hf = 1'b0, go = 1'b1;
  logic        pwe = 1'b0, priv = 1'b1, bwe = 1'b0, take, done, req, spf;
  logic [43:0] irq = 44'h0;
  logic [59:0] swp = 60'h0, en = {60{1'b1}}, pend;
  logic [5:0]  psel = 6'h0, vec;
  logic [2:0]  pval = 3'h0;
  logic [31:0] bval = 32'h0, addr, base, nb, lfsr = 32'h239c50b8;
  logic [4:0]  lvl;
  logic [7:0]  hold = 8'h03;
  logic [37:0] q[$];
  int          failures = 0, checks = 0, n;
  int          vs[6] = '{2, 3, 17, 19, 16, 18};

  initial forever #50 clk = ~clk;

  epv_core i_epv_core (.ref_clk_i(clk), .rstn_i(rstn), .irq_line_i(irq),
    .nmi_i(nmi), .hard_fault_i(hf), .sw_pend_i(swp), .enable_i(en),
    .pri_we_i(pwe), .pri_sel_i(psel), .pri_val_i(pval), .priv_i(priv),
    .base_we_i(bwe), .base_val_i(bval), .take_i(take), .done_i(done),
    .req_o(req), .vec_o(vec), .fetch_addr_o(addr), .sp_fetch_o(spf),
    .active_lvl_o(lvl), .base_o(base), .pending_o(pend));
  epv_core_model i_epv_core_model (.clk_i(clk), .req_i(req), .go_i(go),
    .hold_i(hold), .take_o(take), .done_o(done));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  function automatic bit rsv(int v);
    return v < 2 || (v > 6 && v < 11) || v == 13 || v == 25 || v == 28 ||
      v == 29 || v == 42 || v == 43 || (v > 50 && v < 59);
  endfunction : rsv

  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  task automatic chk(string nm, logic [37:0] exp, logic [37:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  // Bounded wait until every noted entry was taken and all handlers left
  task automatic idle();
    n = 0;
    while ((lvl !== EPV_LVL_IDLE || req !== 1'b0 || q.size() != 0)
           && n < 400) begin
      cyc(1);
      n++;
    end
    if (n >= 400) begin
      failures++;
      final_report();
    end
  endtask : idle

  task automatic raise(int v);
    if (v == 2) nmi = 1'b1;
    else if (v == 3) hf = 1'b1;
    else if (v >= 16) irq[v-16] = 1'b1;
    else swp[v] = 1'b1;
    cyc(1);
    {nmi, hf, irq, swp} = 106'h0;
  endtask : raise

  task automatic wbase(logic [31:0] v, logic p, logic [31:0] exp);
    bval = v;
    priv = p;
    bwe = 1'b1;
    cyc(1);
    bwe = 1'b0;
    priv = 1'b1;
    cyc(1);
    chk("base", {6'h0, exp}, {6'h0, base});
  endtask : wbase

  task automatic wpri(int v, logic [2:0] p);
    psel = v[5:0];
    pval = p;
    pwe = 1'b1;
    cyc(1);
    pwe = 1'b0;
  endtask : wpri

  // Every accepted winner must match the oldest note
  always @(posedge clk) if (req && take) begin
    if (q.size() == 0) chk("unexpected_take", 38'h0, {vec, addr});
    else chk("vec_addr", q.pop_front(), {vec, addr});
    chk("entry_align", 38'h0, {36'h0, addr[1:0]});
  end

  initial begin
    cyc(8);
    chk("reset", {1'b1, EPV_LVL_IDLE, 32'h0}, {spf, lvl, base});
    rstn = 1'b1;
    cyc(1);
    chk("sp_fetch", 38'h0, {37'h0, spf});
    for (int b = 0; b < 2; b++) begin
      if (b == 1) begin
        nb = (rnd() & 32'h3fff_ff00) | 32'h100;
        wbase(nb, 1'b1, nb);
      end
      for (int v = 0; v < 60; v++) begin
        hold = 8'h1 + 8'(rnd() & 32'h3);
        if (!rsv(v)) q.push_back({v[5:0], bval + 32'(4 * v)});
        raise(v);
        cyc(3);
        chk("reserved", 38'h0, {37'h0, pend[v] & rsv(v)});
        idle();
      end
    end
    wbase(32'h0000_2000, 1'b0, nb);
    wbase(32'h0000_0080, 1'b1, nb);
    wbase(32'h4000_0000, 1'b1, nb);
    wbase(32'h3fff_ff00, 1'b1, 32'h3fff_ff00);
    wbase(32'h1234_56ab, 1'b1, 32'h1234_5600);
    bval = 32'h1234_5600;
    // Stalled core lets all six pend together; tie and range edges
    go = 1'b0;
    wpri(16, 3'h5);
    wpri(17, 3'h3);
    wpri(18, 3'h7);
    wpri(19, 3'h3);
    foreach (vs[i]) q.push_back({vs[i][5:0], bval + 32'(4 * vs[i])});
    swp = 60'h000_0000_000f_000c;
    cyc(1);
    swp = 60'h0;
    cyc(4);
    go = 1'b1;
    idle();
    hold = 8'h28;
    wpri(30, 3'h4);
    wpri(31, 3'h4);
    wpri(32, 3'h1);
    q.push_back({6'h1e, bval + 32'h78});
    raise(30);
    cyc(6);
    raise(31);
    cyc(6);
    chk("equal_no_preempt", {32'h0, 1'b1, 5'h06}, {32'h0, pend[31], lvl});
    q.push_back({6'h20, bval + 32'h80});
    q.push_back({6'h1f, bval + 32'h7c});
    raise(32);
    idle();
    final_report();
  end
endmodule : exception_priority_vector_logic_tb_top
`default_nettype wire
